// ==== rtl/serial_latch_load_port.sv ====
// Serial programming port with load latches, power and observation logic
`timescale 1ns/1ns
`include "serial_latch_defs.svh"
module serial_latch_load_port (
    // System clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Serial link from host
    input  wire logic                     sclk,
    input  wire logic                     sdata,
    input  wire logic                     load_strobe,
    // Power-on control pin
    input  wire logic                     power_on,
    // Internal signals for observation, asynchronous
    input  wire logic                     lock_detect_in,
    input  wire logic                     rf_div_scaled_in,
    input  wire logic                     ref_div_scaled_in,
    // Pump drive from phase detector, same clock
    input  wire logic                     pump_drive,
    // Pump pin
    output      logic                     pump_output,
    output      logic                     pump_output_oe,
    // Observation pin
    output      logic                     observation_output,
    // Power and reference isolation
    output      logic                     powered_down,
    output      logic                     ref_iso_switch_first,
    output      logic                     ref_iso_switch_second,
    output      logic                     ref_iso_switch_third,
    // Latch contents
    output      serial_latch_pkg::words_t latch_words
);
    import serial_latch_pkg::*;

    // Serial clock domain: shift register only
    // Power-up value only, so no shift ever sees unknown older bits
    link_state_t lst = '0;
    link_state_t next_lst;

    always_comb begin
        next_lst = lst;
        next_lst.sreg = {lst.sreg[`WORD_W-2:0], sdata};
    end

    // No reset here: the word is data and the clock may be stopped
    always_ff @(posedge sclk) begin
        lst <= next_lst;
    end

    a_shift_msb_first: assert property (@(posedge sclk)
        disable iff (srst)
        ##1 lst.sreg == {$past(lst.sreg[`WORD_W-2:0]), $past(sdata)})
        else $error("serial word did not shift in the data bit");

    // System clock domain
    core_state_t st;
    core_state_t next_st;
    logic        load_now;
    mux_sel_t    mux_sel;
    logic        pd_bits;

    // The host holds the serial clock still around the strobe, so the
    // word is static when the synchronised strobe edge samples it.
    assign load_now = st.strobe_sync & ~st.strobe_prev;

    latch_bank u_bank (
        .clk     (clk),
        .srst    (srst),
        .wr_en   (load_now),
        .wr_sel  (lst.sreg[`SEL_MSB:`SEL_LSB]),
        .wr_data (lst.sreg),
        .words   (latch_words)
    );

    assign mux_sel = latch_words[`LATCH_CONTROL][`CTRL_MUX_MSB:`CTRL_MUX_LSB];
    assign pd_bits = latch_words[`LATCH_CONTROL][`CTRL_PD1_BIT]
                   | latch_words[`LATCH_CONTROL][`CTRL_PD2_BIT];

    always_comb begin
        next_st = st;
        next_st.ce_meta   = power_on;
        next_st.ce_sync   = st.ce_meta;
        next_st.strobe_meta = load_strobe;
        next_st.strobe_sync = st.strobe_meta;
        next_st.strobe_prev = st.strobe_sync;
        next_st.lock_meta = lock_detect_in;
        next_st.lock_sync = st.lock_meta;
        next_st.rfd_meta  = rf_div_scaled_in;
        next_st.rfd_sync  = st.rfd_meta;
        next_st.refd_meta = ref_div_scaled_in;
        next_st.refd_sync = st.refd_meta;
        // Pin low forces power-down; high defers to programmed bits
        next_st.powered_down = ~st.ce_sync | pd_bits;
        next_st.pump_oe      = ~next_st.powered_down;
        next_st.pump_level   = pump_drive & ~next_st.powered_down;
        next_st.iso_first  = ~next_st.powered_down;
        next_st.iso_second = ~next_st.powered_down;
        next_st.iso_third  = next_st.powered_down;
        case (mux_sel)
            `MUX_LOCK:    next_st.obs = st.lock_sync;
            `MUX_RF_DIV:  next_st.obs = st.rfd_sync;
            `MUX_REF_DIV: next_st.obs = st.refd_sync;
            default:      next_st.obs = 1'b0;
        endcase
    end

    // Reset state is powered down with the pump floating
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{powered_down: 1'b1, iso_third: 1'b1, default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign pump_output           = st.pump_level;
    assign pump_output_oe        = st.pump_oe;
    assign observation_output    = st.obs;
    assign powered_down          = st.powered_down;
    assign ref_iso_switch_first  = st.iso_first;
    assign ref_iso_switch_second = st.iso_second;
    assign ref_iso_switch_third  = st.iso_third;

    a_strobe_loads: assert property (@(posedge clk) disable iff (srst)
        $rose(st.strobe_sync) |-> load_now ##1 !load_now)
        else $error("strobe edge did not give one load");

    a_load_spacing: assert property (@(posedge clk) disable iff (srst)
        load_now |-> $past(!st.strobe_sync) && st.strobe_sync)
        else $error("load without a strobe rising edge");

    a_pump_hiz: assert property (@(posedge clk) disable iff (srst)
        !st.ce_sync |=> !pump_output_oe && powered_down && !pump_output)
        else $error("pump driven while power-on pin low");

    a_pd_bits: assert property (@(posedge clk) disable iff (srst)
        st.ce_sync && !pd_bits |=> !powered_down && pump_output_oe)
        else $error("device not powered up when allowed");

    a_pd_bits_hold: assert property (@(posedge clk) disable iff (srst)
        pd_bits |=> powered_down)
        else $error("powered up despite power-down bits");

    a_obs_lock: assert property (@(posedge clk) disable iff (srst)
        mux_sel == `MUX_LOCK |=> observation_output == $past(st.lock_sync))
        else $error("observation output not showing lock detect");

    a_obs_ref: assert property (@(posedge clk) disable iff (srst)
        mux_sel == `MUX_REF_DIV |=> observation_output == $past(st.refd_sync))
        else $error("observation output not showing reference divider");

    a_ref_switch: assert property (@(posedge clk) disable iff (srst)
        !st.ce_sync |=> ref_iso_switch_third && !ref_iso_switch_first
                        && !ref_iso_switch_second)
        else $error("reference input loaded during power-down");

endmodule : serial_latch_load_port

// ==== rtl/serial_latch_defs.svh ====
// Constants for the serial latch load port
// Operation
// - Each rising serial clock edge shifts data into the 24-bit word.
// - A rising load strobe copies the word into one of four latches.
// - Power-on input low powers down and floats the pump output.
// - Power-on high powers up only if the power-down bits allow it.
// - The observation output shows lock detect, RF or reference divider.
// - Powered down, switch three closes and switches one and two open.
// - Bits 1:0 select control, R counter, N counter or test latch.
`ifndef SERIAL_LATCH_DEFS_SVH
`define SERIAL_LATCH_DEFS_SVH

`define WORD_W          24
`define SEL_MSB         1
`define SEL_LSB         0
`define LATCH_CONTROL   2'h0
`define LATCH_RCOUNT    2'h1
`define LATCH_NCOUNT    2'h2
`define LATCH_TEST      2'h3
`define LATCH_COUNT     4
`define LATCH_RESET     24'h000000
`define CTRL_PD1_BIT    20
`define CTRL_PD2_BIT    21
`define CTRL_MUX_MSB    7
`define CTRL_MUX_LSB    5
`define MUX_LOCK        3'h1
`define MUX_RF_DIV      3'h2
`define MUX_REF_DIV     3'h3

`endif

// ==== rtl/serial_latch_pkg.sv ====
// Types shared by the serial latch load port
`include "serial_latch_defs.svh"
package serial_latch_pkg;

    typedef logic [`WORD_W-1:0]                    word_t;
    typedef logic [`SEL_MSB:`SEL_LSB]              sel_t;
    typedef logic [`LATCH_COUNT-1:0][`WORD_W-1:0]  words_t;
    typedef logic [`CTRL_MUX_MSB-`CTRL_MUX_LSB:0]  mux_sel_t;

    typedef struct packed {
        word_t sreg;
    } link_state_t;

    typedef struct packed {
        words_t words;
    } bank_state_t;

    typedef struct packed {
        logic ce_meta;
        logic ce_sync;
        logic strobe_meta;
        logic strobe_sync;
        logic strobe_prev;
        logic lock_meta;
        logic lock_sync;
        logic rfd_meta;
        logic rfd_sync;
        logic refd_meta;
        logic refd_sync;
        logic powered_down;
        logic pump_oe;
        logic pump_level;
        logic obs;
        logic iso_first;
        logic iso_second;
        logic iso_third;
    } core_state_t;

endpackage : serial_latch_pkg

// ==== rtl/latch_bank.sv ====
// Bank of four programming latches written by load strobe
`timescale 1ns/1ns
`include "serial_latch_defs.svh"
module latch_bank (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // Write port
    input  wire logic                   wr_en,
    input  wire serial_latch_pkg::sel_t  wr_sel,
    input  wire serial_latch_pkg::word_t wr_data,
    // Latch contents
    output      serial_latch_pkg::words_t words
);
    import serial_latch_pkg::*;

    bank_state_t st;
    bank_state_t next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < `LATCH_COUNT; i++) begin
            if (wr_en && wr_sel == sel_t'(i)) begin
                next_st.words[i] = wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{words: {`LATCH_COUNT{`LATCH_RESET}}};
        end else begin
            st <= next_st;
        end
    end

    assign words = st.words;

    a_load_target: assert property (@(posedge clk) disable iff (srst)
        wr_en |=> st.words[$past(wr_sel)] == $past(wr_data))
        else $error("loaded word missing from selected latch");

    a_hold_no_load: assert property (@(posedge clk) disable iff (srst)
        !wr_en |=> $stable(st.words))
        else $error("latch changed without a load");

endmodule : latch_bank

// ==== tb/host_link_model.sv ====
// Host model driving the three-wire serial programming lines
`timescale 1ns/1ns
module host_link_model (
    // Serial link to device
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end

    // Clock stands still between frames; 48 ns period inside a frame
    task automatic send(input logic [23:0] w, input bit strobe);
        for (int i = 23; i >= 0; i--) begin
            sdata = w[i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        // Hold time over, so the data line no longer shows the last bit
        sdata = ~sdata;
        #20 load_strobe = strobe;
        #60 load_strobe = 1'b0;
    endtask : send
endmodule : host_link_model

// ==== tb/serial_latch_load_port_bench.sv ====
// Self-checking bench for the serial latch load port
`timescale 1ns/1ns
`define check(a, b) begin check_count++; if ((a) !== (b)) begin \
    fail_count++; $display("mismatch at %0t: %h %h", $time, (a), (b)); end end
module serial_latch_load_port_bench;
    import serial_latch_pkg::*;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       power_on = 1'b0;
    logic [2:0] src = 3'h0;
    logic       pump_drive = 1'b1;
    logic       sclk, sdata, load_strobe, pump_output, pump_output_oe;
    logic       observation_output, powered_down;
    logic       iso_first, iso_second, iso_third;
    words_t     latch_words;
    words_t     exp_words = '0;
    int         fail_count = 0;
    int         check_count = 0;
    int         cycles = 0;

    initial forever #5 clk = ~clk;

    host_link_model i_host (.sclk(sclk), .sdata(sdata),
        .load_strobe(load_strobe));

    serial_latch_load_port i_dut (.clk(clk), .srst(srst), .sclk(sclk),
        .sdata(sdata), .load_strobe(load_strobe), .power_on(power_on),
        .lock_detect_in(src[0]), .rf_div_scaled_in(src[1]),
        .ref_div_scaled_in(src[2]), .pump_drive(pump_drive),
        .pump_output(pump_output), .pump_output_oe(pump_output_oe),
        .observation_output(observation_output),
        .powered_down(powered_down), .ref_iso_switch_first(iso_first),
        .ref_iso_switch_second(iso_second),
        .ref_iso_switch_third(iso_third),
        .latch_words(latch_words));

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk

    task automatic load(input word_t w, input bit strobe);
        i_host.send(w, strobe);
        if (strobe) exp_words[w[1:0]] = w;
        wait_clk(8);
    endtask : load

    task automatic expect_power(input logic pd);
        `check(powered_down, pd)
        `check(pump_output_oe, ~pd)
        `check(pump_output, ~pd)
        `check({iso_first, iso_second, iso_third}, {~pd, ~pd, pd})
    endtask : expect_power

    task automatic t_reset;
        wait_clk(20);
        expect_power(1'b1);
        `check(latch_words, exp_words)
        srst = 1'b0;
        power_on = 1'b1;
        wait_clk(8);
        expect_power(1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_load;
        word_t w;
        // Test latch is reserved, so the host never addresses it
        for (int i = 0; i < 3; i++) begin
            w = {4'h0, 2'(i), 2'h0, 16'h3A40} | 24'(i);
            load(w, 1'b1);
            `check(latch_words, exp_words)
        end
        $display("test load done");
    endtask : t_load

    task automatic t_no_strobe;
        load(24'hFFFFFE, 1'b0);
        `check(latch_words, exp_words)
        $display("test no_strobe done");
    endtask : t_no_strobe

    task automatic t_observe;
        for (int m = 0; m < 4; m++) begin
            load({16'h0, 3'(m), 5'h0}, 1'b1);
            for (int p = 0; p < 2; p++) begin
                src = p ? 3'h2 : 3'h5;
                wait_clk(6);
                `check(observation_output, m ? src[m-1] : 1'b0)
            end
        end
        $display("test observe done");
    endtask : t_observe

    task automatic t_power;
        power_on = 1'b0;
        wait_clk(5);
        expect_power(1'b1);
        power_on = 1'b1;
        wait_clk(5);
        expect_power(1'b0);
        // Enabled pump must follow its drive, not a fixed level
        pump_drive = 1'b0;
        wait_clk(2);
        `check(pump_output, 1'b0)
        `check(pump_output_oe, 1'b1)
        pump_drive = 1'b1;
        wait_clk(2);
        `check(pump_output, 1'b1)
        load(24'h100000, 1'b1);
        expect_power(1'b1);
        load(24'h200000, 1'b1);
        expect_power(1'b1);
        load(24'h000000, 1'b1);
        expect_power(1'b0);
        $display("test power done");
    endtask : t_power

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Whole run needs about 1500 cycles; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        @(negedge clk);
        t_reset();
        t_load();
        t_no_strobe();
        t_observe();
        t_power();
        conclude();
    end
endmodule : serial_latch_load_port_bench
